// ===== hdl/apif_flag_reg.sv
// Analog and PWM interrupt flag status register with an Avalon-MM slave.
//
// The Avalon-MM interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ns
`include "apif_map.svh"

// One implemented flag position: a source level sets it and a software write stores into it.
// The source is a level, so a source that stays high keeps the flag set however often
// software writes a zero; software must first quiet the source and then clear the flag.
// A written one sets the flag as well, which lets software raise a request for test.
module apif_flag_bit #(
   parameter logic RESET_VAL = 1'b0
) (
   input  wire logic core_clk_i,
   input  wire logic sys_rst_i,
   input  wire logic set_i,
   input  wire logic wr_en_i,
   input  wire logic wr_val_i,
   output logic      flag_o
);
   logic kept;
   logic flag_d;
   logic flag_q;

   // Software's value replaces the stored one only in the cycle in which the write lands.
   assign kept   = wr_en_i ? wr_val_i : flag_q;
   // The source wins over a clear in the same cycle, so a request is never lost.
   assign flag_d = kept | set_i;

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         flag_q <= RESET_VAL;
      end else begin
         flag_q <= flag_d;
      end
   end

   assign flag_o = flag_q;
endmodule

// Top of the block: seven flag positions behind one Avalon-MM word.
// Every access takes exactly one wait cycle: the request is seen with waitrequest high,
// and it completes at the next edge, at which waitrequest is low.
// Read data are captured when the request is first seen and stand until the next read.
// A write lands only at the completing edge, so a request that is withdrawn early has no effect.
// Unmapped addresses ignore writes and read as zero.
// Waitrequest is registered, which costs nothing here because the wait cycle is always taken.
module apif_flag_reg (
   input  wire logic                 core_clk_i,
   input  wire logic                 sys_rst_i,
   input  wire apif_pkg::apif_req_t  req_i,
   input  wire logic [7:0]           avs_address_i,
   input  wire logic                 avs_read_i,
   input  wire logic                 avs_write_i,
   input  wire logic [31:0]          avs_writedata_i,
   input  wire logic [3:0]           avs_byteenable_i,
   output logic      [31:0]          avs_readdata_o,
   output logic                      avs_waitrequest_o,
   output logic      [15:0]          flags_o
);
   import apif_pkg::*;

   // Assembled register word; unimplemented positions are tied to zero.
   logic [15:0]     flags_vec;
   logic [31:0]     rd_word;
   logic            acc;
   logic            hit;
   logic            lane_lo;
   logic            lane_hi;
   logic            wr_land;
   logic            rd_take;
   logic            we_lo;
   logic            we_hi;

   // Bus handshake state; waitrequest has its own flop so that the port comes straight from one.
   apif_bus_state_t state_q;
   apif_bus_state_t state_d;
   logic            wait_q;
   logic            wait_d;
   logic [31:0]     rdata_q;
   logic [31:0]     rdata_d;

   // Source requests, named for the flag they set.
   logic            set_adc_one;
   logic            set_adc_zero;
   logic            set_cmp_four;
   logic            set_cmp_three;
   logic            set_cmp_two;
   logic            set_pwm_four;
   logic            set_pwm_three;

   // Write enables per flag position, steered by the byte lane that carries it.
   logic            we_adc_one;
   logic            we_adc_zero;
   logic            we_cmp_four;
   logic            we_cmp_three;
   logic            we_cmp_two;
   logic            we_pwm_four;
   logic            we_pwm_three;

   // Write data split per flag position.
   logic            wv_adc_one;
   logic            wv_adc_zero;
   logic            wv_cmp_four;
   logic            wv_cmp_three;
   logic            wv_cmp_two;
   logic            wv_pwm_four;
   logic            wv_pwm_three;

   // Flop outputs of the seven flag positions.
   logic            fl_adc_one;
   logic            fl_adc_zero;
   logic            fl_cmp_four;
   logic            fl_cmp_three;
   logic            fl_cmp_two;
   logic            fl_pwm_four;
   logic            fl_pwm_three;

   // Decode of the request: one word lives at the flag offset, every other address is unmapped.
   assign acc     = avs_read_i | avs_write_i;
   assign hit     = (avs_address_i == `APIF_FLAGS_OFFSET);
   assign lane_lo = avs_byteenable_i[`APIF_LANE_LO];
   assign lane_hi = avs_byteenable_i[`APIF_LANE_HI];

   // A write lands at the edge at which the master sees waitrequest low, and not before.
   assign wr_land = avs_write_i & hit & (state_q == st_ack);
   assign we_lo   = wr_land & lane_lo;
   assign we_hi   = wr_land & lane_hi;

   // Read data are captured as the request is first seen, so they stand at the completing edge.
   assign rd_take = avs_read_i & (state_q == st_idle);

   // Source requests, one per implemented flag.
   assign set_adc_one   = req_i.adc_pair_one_done_flag;
   assign set_adc_zero  = req_i.adc_pair_zero_done_flag;
   assign set_cmp_four  = req_i.comparator_four_flag;
   assign set_cmp_three = req_i.comparator_three_flag;
   assign set_cmp_two   = req_i.comparator_two_flag;
   assign set_pwm_four  = req_i.pwm_gen_four_flag;
   assign set_pwm_three = req_i.pwm_gen_three_flag;

   // Bits 15 to 8 sit in the upper lane, bits 7 to 0 in the lower one.
   assign we_adc_one   = we_hi;
   assign we_adc_zero  = we_hi;
   assign we_cmp_four  = we_hi;
   assign we_cmp_three = we_hi;
   assign we_cmp_two   = we_lo;
   assign we_pwm_four  = we_lo;
   assign we_pwm_three = we_lo;

   // Per-position write values.
   assign wv_adc_one   = avs_writedata_i[`APIF_BIT_ADCP1];
   assign wv_adc_zero  = avs_writedata_i[`APIF_BIT_ADCP0];
   assign wv_cmp_four  = avs_writedata_i[`APIF_BIT_CMP4];
   assign wv_cmp_three = avs_writedata_i[`APIF_BIT_CMP3];
   assign wv_cmp_two   = avs_writedata_i[`APIF_BIT_CMP2];
   assign wv_pwm_four  = avs_writedata_i[`APIF_BIT_PWM4];
   assign wv_pwm_three = avs_writedata_i[`APIF_BIT_PWM3];

   // Register word as software sees it.
   assign flags_vec = {fl_adc_one,
                       fl_adc_zero,
                       4'h0,
                       fl_cmp_four,
                       fl_cmp_three,
                       fl_cmp_two,
                       5'h00,
                       fl_pwm_four,
                       fl_pwm_three
                       };

   // Conversion done of ADC pair one sets the top position.
   apif_flag_bit #(
      .RESET_VAL (`APIF_FLAG_RESET)
   ) flag_adc_one_inst (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .set_i      (set_adc_one),
      .wr_en_i    (we_adc_one),
      .wr_val_i   (wv_adc_one),
      .flag_o     (fl_adc_one)
   );

   // Conversion done of ADC pair zero sets the position below it.
   apif_flag_bit #(
      .RESET_VAL (`APIF_FLAG_RESET)
   ) flag_adc_zero_inst (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .set_i      (set_adc_zero),
      .wr_en_i    (we_adc_zero),
      .wr_val_i   (wv_adc_zero),
      .flag_o     (fl_adc_zero)
   );

   // Comparator four.
   apif_flag_bit #(
      .RESET_VAL (`APIF_FLAG_RESET)
   ) flag_cmp_four_inst (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .set_i      (set_cmp_four),
      .wr_en_i    (we_cmp_four),
      .wr_val_i   (wv_cmp_four),
      .flag_o     (fl_cmp_four)
   );

   // Comparator three.
   apif_flag_bit #(
      .RESET_VAL (`APIF_FLAG_RESET)
   ) flag_cmp_three_inst (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .set_i      (set_cmp_three),
      .wr_en_i    (we_cmp_three),
      .wr_val_i   (wv_cmp_three),
      .flag_o     (fl_cmp_three)
   );

   // Comparator two sits in the lower byte lane, unlike the other comparators.
   apif_flag_bit #(
      .RESET_VAL (`APIF_FLAG_RESET)
   ) flag_cmp_two_inst (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .set_i      (set_cmp_two),
      .wr_en_i    (we_cmp_two),
      .wr_val_i   (wv_cmp_two),
      .flag_o     (fl_cmp_two)
   );

   // PWM generator four.
   apif_flag_bit #(
      .RESET_VAL (`APIF_FLAG_RESET)
   ) flag_pwm_four_inst (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .set_i      (set_pwm_four),
      .wr_en_i    (we_pwm_four),
      .wr_val_i   (wv_pwm_four),
      .flag_o     (fl_pwm_four)
   );

   // PWM generator three.
   apif_flag_bit #(
      .RESET_VAL (`APIF_FLAG_RESET)
   ) flag_pwm_three_inst (
      .core_clk_i (core_clk_i),
      .sys_rst_i  (sys_rst_i),
      .set_i      (set_pwm_three),
      .wr_en_i    (we_pwm_three),
      .wr_val_i   (wv_pwm_three),
      .flag_o     (fl_pwm_three)
   );

   // Idle until a request arrives, then one cycle with waitrequest low to complete it.
   // A master that keeps its request up starts a new access right after the completing edge.
   always_comb begin
      state_d = state_q;
      case (state_q)
         st_idle: begin
            if (acc) begin
               state_d = st_ack;
            end
         end
         st_ack: begin
            state_d = st_idle;
         end
         default: begin
            state_d = st_idle;
         end
      endcase
   end

   // Waitrequest drops only for the cycle that follows a newly seen request.
   assign wait_d = ~((state_q == st_idle) & acc);

   // Unmapped reads return zero; the upper half of the word is always zero.
   assign rd_word = {16'h0000, flags_vec};
   assign rdata_d = rd_take ? (hit ? rd_word : `APIF_UNMAPPED_DATA) : rdata_q;

   always_ff @(posedge core_clk_i) begin
      if (sys_rst_i) begin
         state_q <= st_idle;
         wait_q  <= `APIF_WAIT_RESET;
         rdata_q <= `APIF_RDATA_RESET;
      end else begin
         state_q <= state_d;
         wait_q  <= wait_d;
         rdata_q <= rdata_d;
      end
   end

   // All outputs come from flops.
   assign avs_waitrequest_o = wait_q;
   assign avs_readdata_o    = rdata_q;
   assign flags_o           = flags_vec;
endmodule

// ===== include/apif_map.svh
// Register offsets, field positions and reset values of the analog and PWM interrupt flag register.
`ifndef APIF_MAP_SVH
`define APIF_MAP_SVH
`define APIF_FLAGS_OFFSET   8'h00
`define APIF_ADDR_W         8
`define APIF_FLAGS_RESET    16'h0000
`define APIF_IMPL_MASK      16'hC383
`define APIF_BIT_ADCP1      15
`define APIF_BIT_ADCP0      14
`define APIF_BIT_CMP4       9
`define APIF_BIT_CMP3       8
`define APIF_BIT_CMP2       7
`define APIF_BIT_PWM4       1
`define APIF_BIT_PWM3       0
`define APIF_UNMAPPED_DATA  32'h00000000
`define APIF_FLAG_RESET     1'b0
`define APIF_WAIT_RESET     1'b1
`define APIF_RDATA_RESET    32'h00000000
`define APIF_LANE_LO        0
`define APIF_LANE_HI        1
`endif

// ===== include/apif_pkg.sv
// Types shared by the analog and PWM interrupt flag register.
package apif_pkg;
   typedef struct packed {
      logic adc_pair_one_done_flag;
      logic adc_pair_zero_done_flag;
      logic comparator_four_flag;
      logic comparator_three_flag;
      logic comparator_two_flag;
      logic pwm_gen_four_flag;
      logic pwm_gen_three_flag;
   } apif_req_t;

   typedef enum logic {
      st_idle,
      st_ack
   } apif_bus_state_t;
endpackage

// ===== test/apif_chk_asserts.sv
// Concurrent checks on the ports of the analog and PWM interrupt flag register.
`timescale 1ns/1ns
module apif_chk (
   input wire logic                core_clk_i,
   input wire logic                sys_rst_i,
   input wire apif_pkg::apif_req_t req_i,
   input wire logic [7:0]          avs_address_i,
   input wire logic                avs_read_i,
   input wire logic                avs_write_i,
   input wire logic [31:0]         avs_writedata_i,
   input wire logic [3:0]          avs_byteenable_i,
   input wire logic [31:0]         avs_readdata_o,
   input wire logic                avs_waitrequest_o,
   input wire logic [15:0]         flags_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence write_lands;
      avs_write_i && !avs_waitrequest_o && (avs_address_i == 8'h00) && (avs_byteenable_i[1:0] == 2'h3)
         && (req_i == 7'h00);
   endsequence

   sequence request_waits;
      (avs_read_i || avs_write_i) && avs_waitrequest_o;
   endsequence

   top_set_a: assert property (req_i[6] |=> flags_o[15]) else $error("top flag not set");
   next_set_a: assert property (req_i[5] |=> flags_o[14]) else $error("second flag not set");
   flag_hold_a: assert property (!avs_write_i |=> ((flags_o & $past(flags_o)) == $past(flags_o)))
      else $error("flag dropped without a write");
   write_store_a: assert property (write_lands |=> (flags_o == ($past(avs_writedata_i[15:0]) & 16'hC383)))
      else $error("written value not stored");
   reset_zero_a: assert property (disable iff (1'b0) sys_rst_i |=> (flags_o == 16'h0000))
      else $error("flags not zero after reset");
   gap_zero_a: assert property (!(flags_o & 16'h3C7C)) else $error("gap bit set");
   low_set_a: assert property (((flags_o[9:7] & $past(req_i[4:2])) == $past(req_i[4:2]))
      && ((flags_o[1:0] & $past(req_i[1:0])) == $past(req_i[1:0])))
      else $error("comparator or PWM flag not set");
   one_wait_a: assert property (request_waits |=> !avs_waitrequest_o) else $error("more than one wait cycle");
endmodule
bind apif_flag_reg apif_chk apif_chk_inst (.*);

// ===== test/apif_flag_reg_tb.sv
// Bench for the analog and PWM interrupt flag register.
`timescale 1ns/1ns
module apif_flag_reg_tb;
   import apif_pkg::*;

   typedef struct packed {
      logic [6:0]  req;
      logic [15:0] flags;
   } apif_row_t;

   localparam int ROWS      = 5;
   localparam int BUS_LIMIT = 20;
   localparam int RUN_LIMIT = 5000;

   // Each row: source requests raised for one cycle, and the word that must read back.
   apif_row_t   rows [ROWS] = '{'{7'h40, 16'h8000},
                                '{7'h20, 16'h4000},
                                '{7'h1C, 16'h0380},
                                '{7'h03, 16'h0003},
                                '{7'h7F, 16'hC383}};

   logic        core_clk_i;
   logic        sys_rst_i;
   apif_req_t   req_i;
   logic [7:0]  avs_address_i;
   logic        avs_read_i;
   logic        avs_write_i;
   logic [31:0] avs_writedata_i;
   logic [3:0]  avs_byteenable_i;
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   logic [15:0] flags_o;
   logic [31:0] rd_data;
   int          err_count;
   int          samples_checked;

   apif_flag_reg apif_flag_reg_inst (
      .core_clk_i        (core_clk_i),
      .sys_rst_i         (sys_rst_i),
      .req_i             (req_i),
      .avs_address_i     (avs_address_i),
      .avs_read_i        (avs_read_i),
      .avs_write_i       (avs_write_i),
      .avs_writedata_i   (avs_writedata_i),
      .avs_byteenable_i  (avs_byteenable_i),
      .avs_readdata_o    (avs_readdata_o),
      .avs_waitrequest_o (avs_waitrequest_o),
      .flags_o           (flags_o)
   );

   task automatic check_val(input string name, input logic [31:0] exp_v, input logic [31:0] seen_v);
      samples_checked++;
      if (seen_v !== exp_v) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", name, exp_v, seen_v);
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d errors %0d", samples_checked, err_count);
      if ((err_count == 0) && (samples_checked > 0)) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // Called just after a rising edge; returns just after the edge that follows completion.
   task automatic bus_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                           input logic [3:0] be, output logic [31:0] rdata);
      int n;
      avs_write_i      <= wr;
      avs_read_i       <= ~wr;
      avs_address_i    <= addr;
      avs_writedata_i  <= wdata;
      avs_byteenable_i <= be;
      n = 0;
      @(posedge core_clk_i);
      while (avs_waitrequest_o && (n < BUS_LIMIT)) begin
         @(posedge core_clk_i);
         n++;
      end
      if (avs_waitrequest_o) begin
         err_count++;
         $display("wrong value waitrequest expected 0 seen 1");
         print_verdict();
      end
      rdata = avs_readdata_o;
      avs_write_i <= 1'b0;
      avs_read_i  <= 1'b0;
      @(posedge core_clk_i);
   endtask

   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   initial begin
      repeat (RUN_LIMIT) @(posedge core_clk_i);
      err_count++;
      $display("wrong value run length expected below %0d seen %0d", RUN_LIMIT, RUN_LIMIT);
      print_verdict();
   end

   initial begin
      err_count        = 0;
      samples_checked  = 0;
      sys_rst_i        = 1'b1;
      req_i            = '0;
      avs_address_i    = 8'h00;
      avs_read_i       = 1'b0;
      avs_write_i      = 1'b0;
      avs_writedata_i  = 32'h00000000;
      avs_byteenable_i = 4'hF;
      repeat (5) @(posedge core_clk_i);
      check_val("flags in reset", 32'h00000000, {16'h0000, flags_o});
      check_val("readdata in reset", 32'h00000000, avs_readdata_o);
      sys_rst_i <= 1'b0;
      @(posedge core_clk_i);
      @(posedge core_clk_i);
      check_val("flags after reset", 32'h00000000, {16'h0000, flags_o});
      foreach (rows[i]) begin
         req_i <= rows[i].req;
         @(posedge core_clk_i);
         req_i <= '0;
         bus_xfer(1'b0, 8'h00, 32'h00000000, 4'hF, rd_data);
         check_val("read after request", {16'h0000, rows[i].flags}, rd_data);
         bus_xfer(1'b1, 8'h00, 32'h00000000, 4'hF, rd_data);
         check_val("flags after clear", 32'h00000000, {16'h0000, flags_o});
      end
      // Software writes all ones: only implemented positions take it.
      bus_xfer(1'b1, 8'h00, 32'h0000FFFF, 4'hF, rd_data);
      check_val("flags after write ones", 32'h0000C383, {16'h0000, flags_o});
      bus_xfer(1'b0, 8'h00, 32'h00000000, 4'hF, rd_data);
      check_val("read after write ones", 32'h0000C383, rd_data);
      // Unmapped address: write ignored, read zero.
      bus_xfer(1'b1, 8'h04, 32'h00000000, 4'hF, rd_data);
      check_val("flags after unmapped write", 32'h0000C383, {16'h0000, flags_o});
      bus_xfer(1'b0, 8'h04, 32'h00000000, 4'hF, rd_data);
      check_val("unmapped read", 32'h00000000, rd_data);
      repeat (5) @(posedge core_clk_i);
      check_val("flags held", 32'h0000C383, {16'h0000, flags_o});
      // Upper lane only: upper flags cleared, lower ones kept.
      bus_xfer(1'b1, 8'h00, 32'h00000000, 4'h2, rd_data);
      check_val("flags after upper lane clear", 32'h00000083, {16'h0000, flags_o});
      bus_xfer(1'b1, 8'h00, 32'h00000000, 4'hF, rd_data);
      check_val("flags after full clear", 32'h00000000, {16'h0000, flags_o});
      // A source held through a clearing write keeps its flag set.
      req_i <= 7'h40;
      bus_xfer(1'b1, 8'h00, 32'h00000000, 4'hF, rd_data);
      req_i <= '0;
      check_val("set wins over clear", 32'h00008000, {16'h0000, flags_o});
      // Reset in mid-run clears the flags, and the first read afterwards returns zero after its one wait cycle.
      sys_rst_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      sys_rst_i <= 1'b0;
      @(posedge core_clk_i);
      check_val("flags after second reset", 32'h00000000, {16'h0000, flags_o});
      bus_xfer(1'b0, 8'h00, 32'h00000000, 4'hF, rd_data);
      check_val("read after second reset", 32'h00000000, rd_data);
      print_verdict();
   end
endmodule
